// ---- rtl/fault_status_cfg.svh ----
// constants for the supply and memory fault status block
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH
// register byte addresses (printed offsets are indexes, address = 4*index)
`define SUPPLY_STATUS_IDX 8'h02
`define MEMORY_STATUS_IDX 8'h03
`define CONTROL_IDX 8'h10
`define SUPPLY_STATUS_ADDR 12'h008
`define MEMORY_STATUS_ADDR 12'h00c
`define CONTROL_ADDR 12'h040
`define WATCH_ADDR 12'h044
// supply status bit positions
`define SUP_BUF_LOW_BIT 7
`define SUP_BUS_LOW_BIT 6
`define SUP_BUF_HIGH_BIT 5
`define SUP_ANALOG_BIT 3
`define SUP_DIGITAL_BIT 2
`define SUP_OTP_BIT 1
`define SUP_CONT_BIT 0
// memory status bit positions
`define MEM_FACTORY_BIT 7
`define MEM_USER_BIT 6
`define MEM_CHECK_BIT 5
`define MEM_WRITE_BIT 4
`define MEM_TEMP_BIT 2
// control register bits
`define CTL_INIT_DONE_BIT 7
`define CTL_REPORT_DIS_BIT 3
`define CTL_PSI5_BIT 0
// reset values
`define MEM_STATUS_RST 8'h00
`define CONTROL_RST 8'h00
// supply recovery time in microseconds, clock period in ns
`define SUPPLY_RECOVERY_US 1000
`define CLK_PERIOD_NS 100
`define SUPPLY_RECOVERY_CYC ((`SUPPLY_RECOVERY_US * 1000) / `CLK_PERIOD_NS)
`endif

// ---- rtl/fault_status_pkg.sv ----
// types for the supply and memory fault status block
package fault_status_pkg;
   typedef logic [7:0] status_byte_t;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_setup = 3'b010,
      st_access = 3'b100
   } apb_state_t;
endpackage : fault_status_pkg

// ---- rtl/supply_memory_fault_status.sv ----
// supply and memory fault status registers behind an apb slave
//
// Contract
// - buffer supply low sets its flag
// - bus input low sets its flag
// - buffer supply high sets its flag
// - analog regulator out of window sets flag
// - digital regulator out of window sets flag
// - otp regulator out of window sets flag
// - continuity break sets its flag
// - any supply fault reloads shared recovery timer
// - memory status bits 7,6,5,4,2, reset zero
// - factory otp fault sets its flag
// - user otp fault sets its flag
// - read or report clears memory faults
// - after init done, recompute check continuously
// - check mismatch sets check fault flag
// - write-in-progress high during otp programming
// - write-in-progress self clears, reads ignored
// - no fault: timer counts down to zero
// - psi5 or reporting off: mute, autoclear
// - summary flag is or of memory bits
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module supply_memory_fault_status
   import fault_status_pkg::*;
#(
   parameter int RECOVERY_CYCLES = `SUPPLY_RECOVERY_CYC,
   parameter int TIMER_W = 16,
   parameter int WATCH_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic buffer_supply_low_in,
   input wire logic bus_input_low_in,
   input wire logic buffer_supply_high_in,
   input wire logic analog_regulator_out_in,
   input wire logic digital_regulator_out_in,
   input wire logic otp_regulator_out_in,
   input wire logic continuity_break_in,
   input wire logic temperature_fault_in,
   input wire logic factory_otp_fault,
   input wire logic user_otp_fault,
   input wire logic otp_program_busy,
   input wire logic [WATCH_W-1:0] watched_regs,
   input wire logic report_supply,
   input wire logic report_memory,
   output logic transmit_enable,
   output logic supply_fault_summary,
   output logic memory_temperature_summary_flag,
   output logic [TIMER_W-1:0] recovery_timer
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   localparam int NPIN = 8;
   logic [NPIN-1:0] pin_meta_r;
   logic [NPIN-1:0] pin_sync_r;
   logic [NPIN-1:0] pin_raw;
   assign pin_raw = {temperature_fault_in, buffer_supply_low_in, bus_input_low_in, buffer_supply_high_in,
                     analog_regulator_out_in, digital_regulator_out_in, otp_regulator_out_in, continuity_break_in};

   // monitors are analog, so each pin passes two flop stages before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else if (clk_en) begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   logic temp_now;
   logic [6:0] supply_now;
   assign temp_now = pin_sync_r[7];
   assign supply_now = pin_sync_r[6:0];

   // ************************************************************
   // apb slave
   // ************************************************************
   logic rd_access;
   logic wr_access;
   logic addr_known;
   assign rd_access = psel && penable && !pwrite && clk_en;
   assign wr_access = psel && penable && pwrite && clk_en;
   assign pready = 1'b1;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `SUPPLY_STATUS_ADDR) || (a == `MEMORY_STATUS_ADDR) ||
                  (a == `CONTROL_ADDR) || (a == `WATCH_ADDR);
   endfunction : is_mapped

   assign addr_known = is_mapped(paddr);
   assign pslverr = psel && penable && !addr_known;

   logic rd_supply;
   logic rd_memory;
   assign rd_supply = rd_access && (paddr == `SUPPLY_STATUS_ADDR);
   assign rd_memory = rd_access && (paddr == `MEMORY_STATUS_ADDR);

   // ************************************************************
   // control register
   // ************************************************************
   status_byte_t control_r;
   logic init_done;
   logic report_disable;
   logic psi5_mode;
   assign init_done = control_r[`CTL_INIT_DONE_BIT];
   assign report_disable = control_r[`CTL_REPORT_DIS_BIT];
   assign psi5_mode = control_r[`CTL_PSI5_BIT];

   // init done is sticky until reset; once set, other bits freeze
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_r <= `CONTROL_RST;
      end else if (wr_access && paddr == `CONTROL_ADDR && pstrb[0] && !init_done) begin
         control_r <= pwdata[7:0];
      end
   end

   // ************************************************************
   // recovery timer
   // ************************************************************
   logic any_supply;
   logic [TIMER_W-1:0] timer_r;
   assign any_supply = |supply_now;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_r <= '0;
      end else if (clk_en) begin
         if (any_supply) begin
            timer_r <= TIMER_W'(RECOVERY_CYCLES);
         end else if (timer_r != '0) begin
            timer_r <= timer_r - 1'b1;
         end
      end
   end
   assign recovery_timer = timer_r;

   // ************************************************************
   // supply status flags
   // ************************************************************
   status_byte_t supply_r;
   status_byte_t supply_set;
   logic timer_zero;
   logic auto_clear;
   logic supply_clear;
   assign timer_zero = (timer_r == '0);
   assign auto_clear = psi5_mode || report_disable;

   always_comb begin
      supply_set = '0;
      supply_set[`SUP_BUF_LOW_BIT] = supply_now[6];
      supply_set[`SUP_BUS_LOW_BIT] = supply_now[5];
      supply_set[`SUP_BUF_HIGH_BIT] = supply_now[4];
      supply_set[`SUP_ANALOG_BIT] = supply_now[3];
      supply_set[`SUP_DIGITAL_BIT] = supply_now[2];
      supply_set[`SUP_OTP_BIT] = supply_now[1];
      supply_set[`SUP_CONT_BIT] = supply_now[0];
   end

   // a clear is only honoured once the timer has run out
   assign supply_clear = timer_zero && (auto_clear || rd_supply || report_supply);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_r <= '0;
      end else if (clk_en) begin
         // set wins over clear
         supply_r <= supply_set | (supply_clear ? 8'h00 : supply_r);
      end
   end

   // muted while the timer runs in psi5 or with reporting off
   assign transmit_enable = !(auto_clear && !timer_zero);
   assign supply_fault_summary = |supply_r;

   // ************************************************************
   // register array check
   // ************************************************************
   logic [WATCH_W-1:0] check_ref_r;
   logic check_armed_r;
   logic check_mismatch;
   assign check_mismatch = check_armed_r && (watched_regs != check_ref_r);

   // reference code taken at the first cycle after init done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         check_ref_r <= '0;
         check_armed_r <= 1'b0;
      end else if (clk_en && init_done && !check_armed_r) begin
         check_ref_r <= watched_regs;
         check_armed_r <= 1'b1;
      end
   end

   // ************************************************************
   // memory status flags
   // ************************************************************
   status_byte_t memory_r;
   logic mem_clear;
   assign mem_clear = rd_memory || report_memory;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_r <= `MEM_STATUS_RST;
      end else if (clk_en) begin
         memory_r[`MEM_FACTORY_BIT] <= factory_otp_fault || (memory_r[`MEM_FACTORY_BIT] && !mem_clear);
         memory_r[`MEM_USER_BIT] <= user_otp_fault || (memory_r[`MEM_USER_BIT] && !mem_clear);
         memory_r[`MEM_CHECK_BIT] <= check_mismatch || (memory_r[`MEM_CHECK_BIT] && !mem_clear);
         memory_r[`MEM_WRITE_BIT] <= otp_program_busy;
         memory_r[`MEM_TEMP_BIT] <= temp_now || (memory_r[`MEM_TEMP_BIT] && !mem_clear);
         memory_r[3] <= 1'b0;
         memory_r[1:0] <= 2'b00;
      end
   end

   assign memory_temperature_summary_flag = |memory_r;

   // ************************************************************
   // read data
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (clk_en && psel && !penable && !pwrite) begin
         // captured in setup so access phase ends in one cycle
         case (paddr)
            `SUPPLY_STATUS_ADDR: prdata <= {24'h000000, supply_r};
            `MEMORY_STATUS_ADDR: prdata <= {24'h000000, memory_r};
            `CONTROL_ADDR: prdata <= {24'h000000, control_r};
            `WATCH_ADDR: prdata <= {{(32-WATCH_W){1'b0}}, check_ref_r};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule : supply_memory_fault_status

// ---- testbench/fault_status_checker.sv ----
// concurrent checks on the fault status block ports
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module fault_status_checker #(
   parameter int RECOVERY_CYCLES = 5,
   parameter int TIMER_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic buffer_supply_low_in,
   input wire logic bus_input_low_in,
   input wire logic buffer_supply_high_in,
   input wire logic analog_regulator_out_in,
   input wire logic digital_regulator_out_in,
   input wire logic otp_regulator_out_in,
   input wire logic continuity_break_in,
   input wire logic factory_otp_fault,
   input wire logic user_otp_fault,
   input wire logic otp_program_busy,
   input wire logic transmit_enable,
   input wire logic supply_fault_summary,
   input wire logic memory_temperature_summary_flag,
   input wire logic [TIMER_W-1:0] recovery_timer
);
   // raw pins; the design syncs them, hence the repeat counts below
   wire logic fault = buffer_supply_low_in | bus_input_low_in | buffer_supply_high_in | analog_regulator_out_in
      | digital_regulator_out_in | otp_regulator_out_in | continuity_break_in;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sup_set; (fault && clk_en) [*3] |=> supply_fault_summary; endproperty
   a_sup_set: assert property (p_sup_set)
      else $error("supply flag not set");
   property p_reload; (fault && clk_en) [*3] |=> recovery_timer == TIMER_W'(RECOVERY_CYCLES); endproperty
   a_reload: assert property (p_reload)
      else $error("timer not reloaded");
   property p_count; (!fault && clk_en) [*4] ##0 recovery_timer != 0
      |=> recovery_timer == $past(recovery_timer) - 1'b1; endproperty
   a_count: assert property (p_count)
      else $error("timer not counting down");
   property p_zero; (!fault && clk_en) [*4] ##0 recovery_timer == 0 |=> recovery_timer == 0; endproperty
   a_zero: assert property (p_zero)
      else $error("timer left zero");
   property p_xmit; recovery_timer == 0 |-> transmit_enable; endproperty
   a_xmit: assert property (p_xmit)
      else $error("transmit muted at zero");
   property p_otp; (factory_otp_fault || user_otp_fault) && clk_en |=> memory_temperature_summary_flag; endproperty
   a_otp: assert property (p_otp)
      else $error("otp fault not flagged");
   property p_busy; otp_program_busy && clk_en |=> memory_temperature_summary_flag; endproperty
   a_busy: assert property (p_busy)
      else $error("write activity not flagged");
   property p_rsvd; psel && !penable && !pwrite && clk_en && paddr == `MEMORY_STATUS_ADDR
      |=> prdata[31:8] == 24'h0 && prdata[3] == 1'b0 && prdata[1:0] == 2'h0; endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits not zero");
endmodule : fault_status_checker

// ---- testbench/status_reader_model.sv ----
// apb master standing in for the status reader
`timescale 1ns/1ps
module status_reader_model (
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // byte registers: only the low byte carries data
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q,
      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
endmodule : status_reader_model

// ---- testbench/supply_memory_fault_status_tb_top.sv ----
// self-checking bench for the supply and memory fault status block
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module supply_memory_fault_status_tb_top import fault_status_pkg::*; ;
   localparam int RC = 5;
   localparam logic [11:0] sup_a = `SUPPLY_STATUS_ADDR;
   localparam logic [11:0] mem_a = `MEMORY_STATUS_ADDR;
   logic pclk, presetn, clk_en, factory_otp_fault, user_otp_fault, otp_program_busy;
   logic temperature_fault_in, report_supply, report_memory, e;
   logic [6:0] sup;
   logic [7:0] watched_regs;
   status_byte_t q;
   int err_count = 0;
   int comparisons = 0;
   wire logic psel, penable, pwrite, pready, pslverr, transmit_enable, supply_fault_summary;
   wire logic memory_temperature_summary_flag;
   wire logic [11:0] paddr;
   wire logic [31:0] pwdata, prdata;
   wire logic [3:0] pstrb;
   wire logic [15:0] recovery_timer;
   supply_memory_fault_status #(.RECOVERY_CYCLES(RC)) DUT (.*, .buffer_supply_low_in(sup[6]),
      .bus_input_low_in(sup[5]), .buffer_supply_high_in(sup[4]), .analog_regulator_out_in(sup[3]),
      .digital_regulator_out_in(sup[2]), .otp_regulator_out_in(sup[1]), .continuity_break_in(sup[0]));
   status_reader_model bus (.*);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      comparisons++;
      if (g !== x) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic rdchk(input string n, input logic [11:0] a, input status_byte_t x);
      bus.xfer(1'b0, a, 8'h00, q, e);
      chk(n, x, q);
   endtask : rdchk
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic t_reset;
      rdchk("memory reset", mem_a, `MEM_STATUS_RST);
      chk("transmit reset", 1'b1, transmit_enable);
      bus.xfer(1'b0, 12'h0f0, 8'h00, q, e);
      chk("unmapped error", 1'b1, e);
      $display("reset test done");
   endtask : t_reset
   task automatic t_supply;
      for (int i = 0; i < 7; i++) begin
         logic [6:0] p;
         status_byte_t ex;
         p = 7'h01 << i;
         ex = {p[6:4], 1'b0, p[3:0]};
         sup <= p;
         cyc(4);
         chk("timer reload", RC, recovery_timer);
         sup <= 7'h00;
         cyc(3);
         rdchk("supply flag", sup_a, ex);
         cyc(RC + 2);
         chk("timer zero", 16'h0, recovery_timer);
         // odd passes cleared by a report, even ones by a read
         report_supply <= i[0];
         cyc(1);
         report_supply <= 1'b0;
         if (!i[0]) rdchk("supply late", sup_a, ex);
         rdchk("supply clear", sup_a, 8'h00);
      end
      $display("supply test done");
   endtask : t_supply
   task automatic t_memory;
      factory_otp_fault <= 1'b1;
      user_otp_fault <= 1'b1;
      cyc(1);
      {factory_otp_fault, user_otp_fault} <= 2'b00;
      rdchk("otp faults", mem_a, 8'hc0);
      rdchk("otp read clear", mem_a, 8'h00);
      factory_otp_fault <= 1'b1;
      cyc(1);
      factory_otp_fault <= 1'b0;
      bus.xfer(1'b1, mem_a, 8'h00, q, e);
      rdchk("write ignored", mem_a, 8'h80);
      user_otp_fault <= 1'b1;
      cyc(1);
      user_otp_fault <= 1'b0;
      report_memory <= 1'b1;
      cyc(1);
      report_memory <= 1'b0;
      rdchk("report clear", mem_a, 8'h00);
      otp_program_busy <= 1'b1;
      cyc(2);
      rdchk("busy", mem_a, 8'h10);
      rdchk("busy kept", mem_a, 8'h10);
      otp_program_busy <= 1'b0;
      cyc(2);
      rdchk("busy done", mem_a, 8'h00);
      temperature_fault_in <= 1'b1;
      cyc(3);
      temperature_fault_in <= 1'b0;
      cyc(3);
      rdchk("temperature", mem_a, 8'h04);
      rdchk("temperature clear", mem_a, 8'h00);
      $display("memory test done");
   endtask : t_memory
   task automatic t_modes;
      status_byte_t m[2] = '{8'h01, 8'h08};
      foreach (m[k]) begin
         bus.xfer(1'b1, `CONTROL_ADDR, m[k], q, e);
         sup <= 7'h01;
         cyc(4);
         sup <= 7'h00;
         cyc(3);
         chk("muted", 1'b0, transmit_enable);
         cyc(RC + 2);
         chk("resumed", 1'b1, transmit_enable);
         chk("auto clear", 1'b0, supply_fault_summary);
      end
      bus.xfer(1'b1, `CONTROL_ADDR, 8'h00, q, e);
      $display("mode test done");
   endtask : t_modes
   task automatic t_freeze;
      // enable low: a same-clock fault must not reach the flags
      clk_en <= 1'b0;
      factory_otp_fault <= 1'b1;
      cyc(2);
      factory_otp_fault <= 1'b0;
      clk_en <= 1'b1;
      rdchk("frozen", mem_a, 8'h00);
      $display("freeze test done");
   endtask : t_freeze
   task automatic t_check;
      bus.xfer(1'b1, `CONTROL_ADDR, 8'h80, q, e);
      cyc(2);
      rdchk("check quiet", mem_a, 8'h00);
      watched_regs <= 8'ha5;
      cyc(2);
      watched_regs <= 8'h5a;
      cyc(1);
      rdchk("check fault", mem_a, 8'h20);
      rdchk("check clear", mem_a, 8'h00);
      $display("check test done");
   endtask : t_check
   initial begin
      {presetn, factory_otp_fault, user_otp_fault, otp_program_busy} = 4'h0;
      {temperature_fault_in, report_supply, report_memory, sup} = 10'h000;
      clk_en = 1'b1;
      watched_regs = 8'h5a;
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
      t_reset;
      t_supply;
      t_memory;
      t_modes;
      t_freeze;
      t_check;
      report_and_stop;
   end
   initial begin
      // the whole run needs well under 1000 cycles
      cyc(5000);
      err_count++;
      report_and_stop;
   end
endmodule : supply_memory_fault_status_tb_top
bind supply_memory_fault_status fault_status_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES), .TIMER_W(TIMER_W)) chk (.*);
